// [design/sbc_pkg.sv]
// constants, types and encodings shared by the spi mode control design
package sbc_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RESET_HOLD_US = 1000;
  localparam int unsigned VDD_WAIT_MS = 150;
  localparam int unsigned WDOG_PERIOD_MS = 150;
  localparam int unsigned CS_GAP_US = 15;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned VDD_WAIT_CYC = VDD_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned WDOG_PERIOD_CYC = WDOG_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned WDOG_CLOSED_CYC = WDOG_PERIOD_CYC / 2;

  // ---------------------------------------------------------------------------
  // frame and field layout of control_status_byte
  // ---------------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 8;
  localparam int unsigned SLEW_HI = 7;
  localparam int unsigned SLEW_LO = 6;
  localparam int unsigned PULLUP_BIT = 5;
  localparam int unsigned SW_C_BIT = 4;
  localparam int unsigned SW_A_BIT = 2;
  localparam int unsigned OP_HI = 1;
  localparam int unsigned OP_LO = 0;
  localparam int unsigned RD_EVENT = 7;
  localparam int unsigned RD_SUPPLY_LOW = 4;

  // ---------------------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SLEW_NORMAL = 2'h0;
  localparam logic [1:0] SLEW_SLOW = 2'h1;
  localparam logic [1:0] SLEW_FAST = 2'h2;
  localparam logic [1:0] SLEW_LOWPWR = 2'h3;
  localparam logic [1:0] OP_SLEEP = 2'h0;
  localparam logic [1:0] OP_STOP = 2'h1;
  localparam logic [1:0] OP_WD_CLEAR = 2'h2;
  localparam logic [1:0] OP_NORMAL = 2'h3;
  localparam logic [7:0] LP_CMD_MASK = 8'hde;
  localparam logic [7:0] LP_CMD_VALUE = 8'hc0;
  localparam logic [1:0] SLEW_RST = 2'h0;
  localparam logic [2:0] SW_RST = 3'h0;
  localparam logic PULLUP_RST = 1'b0;
  localparam logic [1:0] OP_RST = 2'h3;

  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_NORMAL_REQ,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP
  } mode_t;

  typedef struct packed {
    logic cs_n;
    logic rx_done;
    logic pwm;
    logic bus_wake;
    logic bus_fault;
    logic ov;
    logic uv;
    logic heat;
    logic switch_thermal_shutdown_flag;
    logic wake_b;
    logic wake_a;
    logic batt;
    logic vdd_ok;
    logic wd_en;
  } pins_t;

endpackage : sbc_pkg

// [design/spi_link_if.sv]
// carrier between the serial shift engine and the mode control logic
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic [7:0] tx_snap;
  logic [7:0] rx_byte;
  logic rx_done;
  modport engine (input tx_snap, output rx_byte, output rx_done);
  modport ctrl (output tx_snap, input rx_byte, input rx_done);
endinterface : spi_link_if
`default_nettype wire

// [design/spi_shift_engine.sv]
// serial shift engine running on the spi clock, cleared by chip select
`timescale 1ns/1ps
`default_nettype none
module spi_shift_engine (
  input wire logic sclk_in,       // spi clock, idles low
  input wire logic cs_n_in,       // chip select, active low
  input wire logic mosi_in,       // serial data from host
  output logic miso_out,          // serial data to host
  output logic miso_oe_out,       // miso driven while selected
  spi_link_if.engine link         // byte and snapshot to control side
);

  // ---------------------------------------------------------------------------
  // frame state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] count;
    logic [7:0] shift;
  } frame_t;

  frame_t fr_reg;
  frame_t fr_next;
  logic [3:0] tx_idx_reg;

  // no edge of sclk arrives outside a frame, so chip select clears the frame
  always_comb begin
    fr_next = fr_reg;
    if (fr_reg.count != 4'(sbc_pkg::FRAME_BITS)) begin
      fr_next.shift = {fr_reg.shift[6:0], mosi_in};
      fr_next.count = fr_reg.count + 4'h1;
    end
  end

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fr_reg <= '0;
    end else begin
      fr_reg <= fr_next;
    end
  end

  // miso moves on the falling edge, msb already out at chip select fall
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      tx_idx_reg <= 4'h0;
    end else begin
      tx_idx_reg <= fr_reg.count;
    end
  end

  assign miso_oe_out = ~cs_n_in;
  assign miso_out = (!cs_n_in && tx_idx_reg < 4'(sbc_pkg::FRAME_BITS)) ?
                    link.tx_snap[3'(7 - tx_idx_reg)] : 1'b0;
  assign link.rx_byte = fr_reg.shift;
  assign link.rx_done = (fr_reg.count == 4'(sbc_pkg::FRAME_BITS));

endmodule : spi_shift_engine
`default_nettype wire

// [design/sbc_spi_mode_control.sv]
// mode sequencing, watchdog and control/status byte of the system basis chip
//
// What this block does
// - each spi frame is one byte, most significant bit first.
// - status is latched at chip select fall and shifted out that frame.
// - read bit 7 set means event latched, lower bits name source.
// - first read after reset shows battery loss in bit 4.
// - bits 7:6 pick slew; 11 requests low power, slew unchanged.
// - any reset clears both slew bits.
// - bit 5 high drives the bus pullup off output in every mode.
// - pullup bit clears only at power-on reset.
// - bits 4:2 enable switches c,b,a; b and a gated by pwm.
// - any reset clears all three switch enables.
// - bits 1:0 choose sleep, stop, normal with clear, normal.
// - a written 10 mode is stored back as 11, staying normal.
// - sleep or stop entered from normal only after two identical commands.
// - first watchdog clear in normal request has no closed window.
// - normal request resets on watchdog timeout or supply undervoltage.
// - normal resets on regulator undervoltage or watchdog failure.
// - stop keeps reset high unless undervoltage; switches off, no watchdog.
// - sleep holds reset low until wake-up with regulator in range.
// - reset mode lasts 1 ms with supply, sleep after 150 ms without.
// - wake is wake input change, bus wake, or cs rise in stop.
// - clear in closed window or missing clear resets the device.
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_mode_control #(
  parameter int unsigned RESET_HOLD_CYCLES = sbc_pkg::RESET_HOLD_CYC,
  parameter int unsigned VDD_WAIT_CYCLES = sbc_pkg::VDD_WAIT_CYC,
  parameter int unsigned WDOG_PERIOD_CYCLES = sbc_pkg::WDOG_PERIOD_CYC,
  parameter int unsigned WDOG_CLOSED_CYCLES = sbc_pkg::WDOG_CLOSED_CYC
) (
  input wire logic clk_in,              // system clock 100 MHz
  input wire logic reset_in,            // power-on reset, sync, high
  input wire logic sclk_in,             // spi clock from host
  input wire logic cs_n_in,             // spi chip select, low active
  input wire logic mosi_in,             // spi data in
  output logic miso_out,                // spi data out
  output logic miso_oe_out,             // miso enable, high drives
  input wire logic pwm_gate_in,         // pwm gate for switches a, b
  input wire logic wake_input_a_in,     // wake input a level
  input wire logic wake_input_b_in,     // wake input b level
  input wire logic bus_wake_in,         // bus wake detected
  input wire logic bus_fault_in,        // bus fault present
  input wire logic supply_ov_in,        // supply overvoltage
  input wire logic supply_uv_in,        // supply undervoltage
  input wire logic battery_loss_in,     // battery loss seen
  input wire logic regulator_heat_in,   // regulator heat warning
  input wire logic switch_thermal_in,   // switch thermal shutdown
  input wire logic vdd_ok_in,           // regulator output in range
  input wire logic watchdog_enable_in,  // watchdog selected
  output logic rst_n_out,               // reset output, low active
  output logic int_n_out,               // event pending, low active
  output logic [1:0] slew_select_out,   // bus slew setting
  output logic bus_pullup_off_out,      // pullup off, follows bit 5 in any mode
  output logic load_switch_a_out,       // switch a on
  output logic load_switch_b_out,       // switch b on
  output logic load_switch_c_out,       // switch c on
  output logic [1:0] op_select_out,     // stored mode bits
  output logic regulator_on_out,        // regulator enabled
  output logic [2:0] mode_out           // current operating mode
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    sbc_pkg::pins_t s1;
    sbc_pkg::pins_t s2;
    sbc_pkg::pins_t prev;
    sbc_pkg::mode_t mode;
    logic [31:0] tmr;
    logic [31:0] wd;
    logic [1:0] slew;
    logic pullup_off;
    logic [2:0] sw_en;
    logic [1:0] op_sel;
    logic [7:0] rx_hold;
    logic rx_valid;
    logic [7:0] lp_byte;
    logic lp_armed;
    logic [6:0] evt;
    logic [6:0] evt_shown;
    logic first_read;
    logic [7:0] snap;
    logic rst_n;
    logic int_n;
    logic reg_on;
    logic [2:0] sw_on;
  } ctl_state_t;

  localparam sbc_pkg::pins_t PINS_RST = '{cs_n: 1'b1, default: 1'b0};
  localparam ctl_state_t ST_INIT = '{
    s1: PINS_RST, s2: PINS_RST, prev: PINS_RST,
    mode: sbc_pkg::MODE_RESET,
    slew: sbc_pkg::SLEW_RST,
    pullup_off: sbc_pkg::PULLUP_RST,
    sw_en: sbc_pkg::SW_RST,
    op_sel: sbc_pkg::OP_RST,
    first_read: 1'b1,
    int_n: 1'b1,
    reg_on: 1'b1,
    default: '0
  };

  ctl_state_t st_reg;
  ctl_state_t st_next;
  sbc_pkg::pins_t pins_now;
  spi_link_if link ();

  function automatic logic is_lp_cmd(input logic [7:0] b);
    is_lp_cmd = (b & sbc_pkg::LP_CMD_MASK) == sbc_pkg::LP_CMD_VALUE;
  endfunction : is_lp_cmd

  function automatic logic reached(input logic [31:0] cnt, input int unsigned lim);
    reached = cnt >= 32'(lim - 1);
  endfunction : reached

  // ---------------------------------------------------------------------------
  // serial engine on the link clock
  // ---------------------------------------------------------------------------
  spi_shift_engine u_engine (
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .miso_out(miso_out),
    .miso_oe_out(miso_oe_out),
    .link(link.engine)
  );

  assign pins_now = '{cs_n: cs_n_in, rx_done: link.rx_done, pwm: pwm_gate_in,
                      bus_wake: bus_wake_in, bus_fault: bus_fault_in, ov: supply_ov_in,
                      uv: supply_uv_in, heat: regulator_heat_in, switch_thermal_shutdown_flag: switch_thermal_in,
                      wake_b: wake_input_b_in, wake_a: wake_input_a_in, batt: battery_loss_in,
                      vdd_ok: vdd_ok_in, wd_en: watchdog_enable_in};

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic cs_fall;
  logic cs_rise;
  logic done_rise;
  logic awake;
  logic wake;
  logic apply;
  logic wd_clear;
  logic fault;
  logic [6:0] new_evt;
  logic [6:0] live;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins_now;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    cs_fall = st_reg.prev.cs_n & ~st_reg.s2.cs_n;
    cs_rise = ~st_reg.prev.cs_n & st_reg.s2.cs_n;
    done_rise = ~st_reg.prev.rx_done & st_reg.s2.rx_done;
    awake = st_reg.mode == sbc_pkg::MODE_NORMAL_REQ || st_reg.mode == sbc_pkg::MODE_NORMAL;
    wake = (st_reg.s2.wake_a ^ st_reg.prev.wake_a) | (st_reg.s2.wake_b ^ st_reg.prev.wake_b) |
           (st_reg.s2.bus_wake & ~st_reg.prev.bus_wake) |
           (cs_rise & st_reg.mode == sbc_pkg::MODE_STOP);
    fault = 1'b0;

    // events latch until reported; a new event wins over the clearing read
    new_evt = {(st_reg.s2.bus_wake & ~st_reg.prev.bus_wake) | (st_reg.s2.bus_fault & ~st_reg.prev.bus_fault),
               st_reg.s2.ov & ~st_reg.prev.ov,
               st_reg.s2.uv & ~st_reg.prev.uv,
               awake & st_reg.s2.heat & ~st_reg.prev.heat,
               awake & st_reg.s2.switch_thermal_shutdown_flag & ~st_reg.prev.switch_thermal_shutdown_flag,
               ~awake & (st_reg.s2.wake_b ^ st_reg.prev.wake_b),
               ~awake & (st_reg.s2.wake_a ^ st_reg.prev.wake_a)};
    st_next.evt = (st_reg.evt & ~(cs_rise ? st_reg.evt_shown : 7'h00)) | new_evt;

    // status snapshot at chip select fall
    live = {st_reg.s2.bus_wake | st_reg.s2.bus_fault, st_reg.s2.ov, st_reg.s2.uv,
            st_reg.s2.heat, st_reg.s2.switch_thermal_shutdown_flag, st_reg.s2.wake_b, st_reg.s2.wake_a};
    if (cs_fall) begin
      st_next.snap = (|st_reg.evt) ? {1'b1, st_reg.evt} : {1'b0, live};
      if (st_reg.first_read) begin
        st_next.snap[sbc_pkg::RD_SUPPLY_LOW] = st_reg.s2.batt;
      end
      st_next.evt_shown = st_reg.evt;
      st_next.first_read = 1'b0;
    end

    // received byte is held, then acted on when the frame closes
    if (done_rise) begin
      st_next.rx_hold = link.rx_byte;
      st_next.rx_valid = 1'b1;
    end
    apply = cs_rise & st_reg.rx_valid & awake;
    if (cs_rise) begin
      st_next.rx_valid = 1'b0;
    end
    wd_clear = apply && st_reg.rx_hold[sbc_pkg::OP_HI:sbc_pkg::OP_LO] == sbc_pkg::OP_WD_CLEAR;
    if (apply) begin
      if (st_reg.rx_hold[sbc_pkg::SLEW_HI:sbc_pkg::SLEW_LO] != sbc_pkg::SLEW_LOWPWR) begin
        st_next.slew = st_reg.rx_hold[sbc_pkg::SLEW_HI:sbc_pkg::SLEW_LO];
      end
      st_next.pullup_off = st_reg.rx_hold[sbc_pkg::PULLUP_BIT];
      st_next.sw_en = st_reg.rx_hold[sbc_pkg::SW_C_BIT:sbc_pkg::SW_A_BIT];
      st_next.op_sel = wd_clear ? sbc_pkg::OP_NORMAL : st_reg.rx_hold[sbc_pkg::OP_HI:sbc_pkg::OP_LO];
      // noise on one frame must not drop the device into low power
      if (is_lp_cmd(st_reg.rx_hold) && st_reg.lp_armed && st_reg.rx_hold == st_reg.lp_byte &&
          st_reg.mode == sbc_pkg::MODE_NORMAL) begin
        st_next.mode = st_reg.rx_hold[sbc_pkg::OP_LO] ? sbc_pkg::MODE_STOP : sbc_pkg::MODE_SLEEP;
        st_next.lp_armed = 1'b0;
      end else begin
        st_next.lp_armed = is_lp_cmd(st_reg.rx_hold);
        st_next.lp_byte = st_reg.rx_hold;
      end
    end

    // mode sequencing
    case (st_reg.mode)
      sbc_pkg::MODE_RESET: begin
        st_next.tmr = st_reg.tmr + 32'h1;
        if (st_reg.s2.vdd_ok != st_reg.prev.vdd_ok) begin
          st_next.tmr = '0;
        end else if (st_reg.s2.vdd_ok && reached(st_reg.tmr, RESET_HOLD_CYCLES)) begin
          st_next.mode = sbc_pkg::MODE_NORMAL_REQ;
          st_next.wd = '0;
        end else if (!st_reg.s2.vdd_ok && reached(st_reg.tmr, VDD_WAIT_CYCLES)) begin
          st_next.mode = sbc_pkg::MODE_SLEEP;
        end
      end
      sbc_pkg::MODE_NORMAL_REQ: begin
        st_next.wd = st_reg.wd + 32'h1;
        if (!st_reg.s2.vdd_ok || st_reg.s2.uv) begin
          fault = 1'b1;
        end else if (wd_clear) begin
          st_next.mode = sbc_pkg::MODE_NORMAL;
          st_next.wd = '0;
        end else if (apply && !st_reg.s2.wd_en && st_reg.rx_hold[sbc_pkg::OP_HI]) begin
          st_next.mode = sbc_pkg::MODE_NORMAL;
        end else if (st_reg.s2.wd_en && reached(st_reg.wd, WDOG_PERIOD_CYCLES)) begin
          fault = 1'b1;
        end
      end
      sbc_pkg::MODE_NORMAL: begin
        st_next.wd = (st_reg.wd == '1) ? st_reg.wd : st_reg.wd + 32'h1;
        if (!st_reg.s2.vdd_ok) begin
          fault = 1'b1;
        end else if (wd_clear) begin
          st_next.wd = '0;
          if (st_reg.s2.wd_en && st_reg.wd < 32'(WDOG_CLOSED_CYCLES)) begin
            fault = 1'b1;
          end
        end else if (st_reg.s2.wd_en && reached(st_reg.wd, WDOG_PERIOD_CYCLES)) begin
          fault = 1'b1;
        end
      end
      sbc_pkg::MODE_STOP: begin
        if (!st_reg.s2.vdd_ok) begin
          fault = 1'b1;
        end else if (wake) begin
          st_next.mode = sbc_pkg::MODE_NORMAL_REQ;
          st_next.wd = '0;
        end
      end
      sbc_pkg::MODE_SLEEP: begin
        // regulator comes back through reset mode before normal request
        if (wake) begin
          st_next.mode = sbc_pkg::MODE_RESET;
          st_next.tmr = '0;
        end
      end
      default: begin
        fault = 1'b1;
      end
    endcase

    // device reset keeps the pullup choice; only power-on clears it
    if (fault) begin
      st_next.mode = sbc_pkg::MODE_RESET;
      st_next.tmr = '0;
      st_next.slew = sbc_pkg::SLEW_RST;
      st_next.sw_en = sbc_pkg::SW_RST;
      st_next.op_sel = sbc_pkg::OP_RST;
      st_next.lp_armed = 1'b0;
      st_next.first_read = 1'b1;
    end

    // registered outputs
    st_next.rst_n = st_next.mode == sbc_pkg::MODE_NORMAL_REQ || st_next.mode == sbc_pkg::MODE_NORMAL ||
                    st_next.mode == sbc_pkg::MODE_STOP;
    st_next.reg_on = st_next.mode != sbc_pkg::MODE_SLEEP;
    st_next.int_n = ~(|st_reg.evt);
    st_next.sw_on = (st_next.mode == sbc_pkg::MODE_NORMAL_REQ || st_next.mode == sbc_pkg::MODE_NORMAL) &&
                    !st_reg.s2.switch_thermal_shutdown_flag ? (st_next.sw_en & {1'b1, st_reg.s2.pwm, st_reg.s2.pwm}) : 3'h0;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= ST_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign link.tx_snap = st_reg.snap;
  assign rst_n_out = st_reg.rst_n;
  assign int_n_out = st_reg.int_n;
  assign slew_select_out = st_reg.slew;
  assign bus_pullup_off_out = st_reg.pullup_off;
  assign load_switch_a_out = st_reg.sw_on[0];
  assign load_switch_b_out = st_reg.sw_on[1];
  assign load_switch_c_out = st_reg.sw_on[2];
  assign op_select_out = st_reg.op_sel;
  assign regulator_on_out = st_reg.reg_on;
  assign mode_out = st_reg.mode;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_reset_mode_low: assert property (st_reg.mode == sbc_pkg::MODE_RESET |-> !rst_n_out)
    else $error("reset output high in reset mode");
  a_sleep_rst_low: assert property (st_reg.mode == sbc_pkg::MODE_SLEEP |-> !rst_n_out && !regulator_on_out)
    else $error("reset output or regulator high in sleep");
  a_stop_switch_off: assert property (st_reg.mode == sbc_pkg::MODE_STOP |-> ##1
                                      (st_reg.mode != sbc_pkg::MODE_STOP || (st_reg.sw_on == 3'h0 && rst_n_out)))
    else $error("switch on or reset low in stop");
  a_lp_two_cmds: assert property (st_reg.mode == sbc_pkg::MODE_NORMAL &&
                                  (st_next.mode == sbc_pkg::MODE_SLEEP || st_next.mode == sbc_pkg::MODE_STOP)
                                  |-> st_reg.lp_armed && st_reg.rx_hold == st_reg.lp_byte && apply)
    else $error("low power entered without repeated command");
  a_wd_clear_back: assert property (apply && !fault &&
                                    st_reg.rx_hold[1:0] == sbc_pkg::OP_WD_CLEAR |=> op_select_out == sbc_pkg::OP_NORMAL)
    else $error("mode bits not restored after watchdog clear");
  a_slew_hold_lp: assert property (apply && !fault &&
                                   st_reg.rx_hold[7:6] == sbc_pkg::SLEW_LOWPWR |=> $stable(slew_select_out))
    else $error("slew changed by low power request");
  a_switch_gate: assert property (load_switch_b_out || load_switch_a_out |->
                                  $past(st_reg.s2.pwm))
    else $error("gated switch on while pwm low");
  a_fault_clears: assert property (fault |=> slew_select_out == sbc_pkg::SLEW_RST &&
                                   st_reg.sw_en == sbc_pkg::SW_RST && mode_out == sbc_pkg::MODE_RESET &&
                                   bus_pullup_off_out == $past(st_reg.pullup_off))
    else $error("device reset did not clear controls");
  a_wd_timeout: assert property (st_reg.mode == sbc_pkg::MODE_NORMAL_REQ && st_reg.s2.wd_en &&
                                 st_reg.s2.vdd_ok && !st_reg.s2.uv && !wd_clear &&
                                 reached(st_reg.wd, WDOG_PERIOD_CYCLES) |=> !rst_n_out)
    else $error("no reset after normal request timeout");
  a_first_batt: assert property (cs_fall && st_reg.first_read |=>
                                 st_reg.snap[sbc_pkg::RD_SUPPLY_LOW] == $past(st_reg.s2.batt))
    else $error("first read does not show battery loss");

  c_enter_sleep: cover property (st_reg.mode == sbc_pkg::MODE_NORMAL ##1 st_reg.mode == sbc_pkg::MODE_SLEEP);
  c_enter_stop: cover property (st_reg.mode == sbc_pkg::MODE_NORMAL ##1 st_reg.mode == sbc_pkg::MODE_STOP);
  c_first_clear: cover property (st_reg.mode == sbc_pkg::MODE_NORMAL_REQ && wd_clear);
  c_event_read: cover property (cs_fall && |st_reg.evt);

endmodule : sbc_spi_mode_control
`default_nettype wire

// [verif/spi_host_model.sv]
// host spi master model sending one byte per frame
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic sclk_out,   // spi clock, still between frames
  output logic cs_n_out,   // chip select, low active
  output logic mosi_out,   // data to device
  input wire logic miso_in // data from device
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // 80 ns link clock only inside the frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    cs_n_out = 1'b0;
    // odd lead keeps sclk edges off the system clock's grid
    #103;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = tx[i];
      #40 sclk_out = 1'b1;
      rx[i] = miso_in;
      #40 sclk_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    // released line must not keep the last bit
    mosi_out = ~tx[0];
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// [verif/sbc_spi_mode_control_bench.sv]
// self-checking bench for the spi mode control block
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_mode_control_bench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sclk, cs_n, mosi, miso, rst_n, pu, sw_a, sw_b, sw_c, oe, reg_on, int_n;
  logic [1:0] slew, op;
  logic [2:0] mode;
  logic [7:0] rx;
  logic [11:0] st = 12'h801;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clk_in = ~clk_in;
  spi_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  sbc_spi_mode_control #(.RESET_HOLD_CYCLES(20), .VDD_WAIT_CYCLES(50), .WDOG_PERIOD_CYCLES(200),
    .WDOG_CLOSED_CYCLES(100)) dut (.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(oe), .pwm_gate_in(st[11]), .wake_input_a_in(st[0]),
    .wake_input_b_in(st[1]), .bus_wake_in(st[2]), .bus_fault_in(st[3]), .supply_ov_in(st[4]),
    .supply_uv_in(st[5]), .battery_loss_in(st[6]), .regulator_heat_in(st[7]), .switch_thermal_in(st[8]),
    .vdd_ok_in(st[9]), .watchdog_enable_in(st[10]), .rst_n_out(rst_n), .int_n_out(int_n),
    .slew_select_out(slew), .bus_pullup_off_out(pu), .load_switch_a_out(sw_a), .load_switch_b_out(sw_b),
    .load_switch_c_out(sw_c), .op_select_out(op), .regulator_on_out(reg_on), .mode_out(mode));
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // gap covers both the cs spacing and the update delay
  task automatic frame(input logic [7:0] tx);
    @(negedge clk_in);
    host.xfer(tx, rx);
    repeat (1500) @(negedge clk_in);
  endtask : frame
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    // battery loss raised, watchdog off, supply good, pwm high
    st = 12'ha40;
    repeat (16) @(negedge clk_in);
    reset_in = 1'b0;
    check({slew, pu, sw_c, sw_b, sw_a, op}, 8'h03);
    check({5'h0, mode}, {5'h0, sbc_pkg::MODE_RESET});
    check({5'h0, oe, reg_on, int_n}, 8'h03);
    for (int i = 0; i < 100; i++) begin
      @(negedge clk_in);
      if (mode === sbc_pkg::MODE_NORMAL_REQ) break;
    end
    check({4'h0, rst_n, mode}, {4'h0, 1'b1, sbc_pkg::MODE_NORMAL_REQ});
    frame(8'h3e);
    check(rx, 8'h10);
    check({slew, pu, sw_c, sw_b, sw_a, op}, 8'h3f);
    check({5'h0, mode}, {5'h0, sbc_pkg::MODE_NORMAL});
    frame(8'h43);
    check(rx, 8'h00);
    check({slew, pu, sw_c, sw_b, sw_a, op}, 8'h43);
    // overvoltage rises: latched, reported once, then shown live
    st[4] = 1'b1;
    repeat (10) @(negedge clk_in);
    check({7'h0, int_n}, 8'h00);
    frame(8'hc1);
    check(rx, 8'ha0);
    check({7'h0, int_n}, 8'h01);
    check({6'h0, slew}, {6'h0, sbc_pkg::SLEW_SLOW});
    check({5'h0, mode}, {5'h0, sbc_pkg::MODE_NORMAL});
    frame(8'hc1);
    check(rx, 8'h20);
    check({4'h0, rst_n, mode}, {4'h0, 1'b1, sbc_pkg::MODE_STOP});
    check({5'h0, sw_c, sw_b, sw_a}, 8'h00);
    // wake input a changes in stop
    st[0] = 1'b1;
    repeat (20) @(negedge clk_in);
    check({3'h0, int_n, rst_n, mode}, {3'h0, 1'b0, 1'b1, sbc_pkg::MODE_NORMAL_REQ});
    frame(8'h83);
    check(rx, 8'h81);
    check({slew, pu, sw_c, sw_b, sw_a, op}, 8'h83);
    check({5'h0, mode}, {5'h0, sbc_pkg::MODE_NORMAL});
    frame(8'he0);
    frame(8'he0);
    check(rx, 8'h21);
    check({3'h0, reg_on, rst_n, mode}, {5'h0, sbc_pkg::MODE_SLEEP});
    check({slew, pu, sw_c, sw_b, sw_a, op}, 8'ha0);
    // wake from sleep with the watchdog on and never cleared
    st[10] = 1'b1;
    st[1] = 1'b1;
    repeat (150) @(negedge clk_in);
    check({4'h0, rst_n, mode}, {4'h0, 1'b1, sbc_pkg::MODE_NORMAL_REQ});
    repeat (80) @(negedge clk_in);
    check({4'h0, rst_n, mode}, {5'h0, sbc_pkg::MODE_RESET});
    check({slew, pu, sw_c, sw_b, sw_a, op}, 8'h23);
    wrap_up();
  end
endmodule : sbc_spi_mode_control_bench
`default_nettype wire
